// ---- logic/pbs_seq.sv ----
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - embedded phy: first clear the interface stop bit in standby control, only if set
// - embedded phy: poll the phy status register until the power-up flag reads 0
// - embedded phy: port c high 2, low 1 to 0000, low 2 to FF00
// - internal clock: program frequency and divider before phy reset
// - write identifier defaults and phy address before the control write
// - enter reset writing reset bit 0 plus the chosen mode bits
// - hold phy reset longer than 100 us before release
// - release by setting only the reset bit to 1, other bits unchanged
// - wait longer than 20 ms after release before any phy access
// - afterwards all embedded phy setup uses mii management frames
// - external phy: port c high 2 to 0155, both low to 5555
// - external phy then configured by mii management frames
module pbs_seq import pbs_pkg::*; #(
	parameter int REL_WAIT = REL_WAIT_CYCLES,
	parameter int STOP_BIT = STOP_BIT_POS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic m_psel,
	output logic m_penable,
	output logic m_pwrite,
	output logic [31:0] m_paddr,
	output logic [31:0] m_pwdata,
	input wire logic [31:0] m_prdata,
	input wire logic m_pready
);

	pbs_state_t state;
	pbs_state_t next_state;
	pbs_req_t req;

	logic cfg_ext;
	logic cfg_intclk;
	logic [2:0] cfg_mode;
	logic [15:0] id_one;
	logic [15:0] id_two;
	logic [4:0] phy_addr;
	logic [15:0] frq_val;
	logic [7:0] mclk_val;
	logic [15:0] stop_val;
	logic [IRQ_WIDTH-1:0] irq_st;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic seq_done;
	logic timer_expired;

	// slave decode
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready & pwrite;
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_status = (paddr == OFS_STATUS);
	wire hit_irq_st = (paddr == OFS_IRQ_STATUS);
	wire hit_irq_mask = (paddr == OFS_IRQ_MASK);
	wire hit_ident = (paddr == OFS_IDENT);
	wire hit_addr = (paddr == OFS_PHY_ADDR);
	wire hit_clock = (paddr == OFS_CLOCK);
	wire mapped = hit_ctrl | hit_status | hit_irq_st | hit_irq_mask | hit_ident | hit_addr |
		hit_clock;
	wire busy = (state != ST_IDLE);
	// config stays frozen while a sequence runs so the device sees one consistent set
	wire cfg_wr = wr_en & ~busy;
	wire start_wr = wr_en & hit_ctrl & pwdata[CTRL_START_BIT];
	wire [2:0] wr_mode = pwdata[CTRL_MODE_LSB +: 3];
	wire start_ok = start_wr & ~busy & (wr_mode != MODE_RESERVED);
	wire start_bad = start_wr & (busy | (wr_mode == MODE_RESERVED));

	wire [31:0] rd_ctrl = {25'h0, cfg_mode, 1'b0, cfg_intclk, cfg_ext, 1'b0};
	wire [31:0] rd_status = {22'h0, state, 3'h0, seq_done, busy};
	wire [31:0] rdata =
		hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_irq_st ? {30'h0, irq_st} :
		hit_irq_mask ? {30'h0, irq_mask} :
		hit_ident ? {id_two, id_one} :
		hit_addr ? {27'h0, phy_addr} :
		hit_clock ? {8'h0, mclk_val, frq_val} : 32'h0;

	// master side
	wire xfer_done = m_psel & m_penable & m_pready;
	wire wait_state = (state == ST_IDLE) | (state == ST_RST_WAIT) | (state == ST_REL_WAIT) |
		(state == ST_DONE);
	wire launch = ~wait_state & ~m_psel;
	wire stop_set = m_prdata[STOP_BIT];
	wire flag_clear = ~m_prdata[SR_POWERUP_BIT];
	wire clksel = ~cfg_intclk;
	wire [15:0] ctrl_word = {1'b1, 1'b0, clksel, 10'h0, cfg_mode};
	wire [15:0] stop_clr = stop_val & ~(16'h1 << STOP_BIT);
	wire timer_load = xfer_done & ((state == ST_CTRL_RST) | (state == ST_CTRL_REL));
	wire [TIMER_WIDTH-1:0] timer_count = (state == ST_CTRL_RST) ?
		TIMER_WIDTH'(RST_HOLD_CYCLES) : TIMER_WIDTH'(REL_WAIT);
	wire seq_finish = (state == ST_DONE);
	wire [IRQ_WIDTH-1:0] irq_set = {start_bad, seq_finish};
	wire [IRQ_WIDTH-1:0] irq_clr = (wr_en & hit_irq_st) ? pwdata[IRQ_WIDTH-1:0] :
		{IRQ_WIDTH{1'b0}};

	always_comb begin
		req = '{write: 1'b1, addr: 32'h0, wdata: 16'h0};
		unique case (state)
			ST_STOP_RD: req = '{write: 1'b0, addr: DEV_STANDBY_CONTROL_FOUR, wdata: 16'h0};
			ST_STOP_WR: req = '{write: 1'b1, addr: DEV_STANDBY_CONTROL_FOUR, wdata: stop_clr};
			ST_PWR_POLL: req = '{write: 1'b0, addr: DEV_PHY_INTERFACE_BLOCK_STATUS_REG, wdata: 16'h0};
			ST_PORT_H2: req = '{write: 1'b1, addr: DEV_PORT_C_FUNCTION_HIGH_2,
				wdata: cfg_ext ? PORT_EXT_HIGH_2 : PORT_EMB_HIGH_2};
			ST_PORT_L1: req = '{write: 1'b1, addr: DEV_PORT_C_FUNCTION_LOW_1,
				wdata: cfg_ext ? PORT_EXT_LOW_1 : PORT_EMB_LOW_1};
			ST_PORT_L2: req = '{write: 1'b1, addr: DEV_PORT_C_FUNCTION_LOW_2,
				wdata: cfg_ext ? PORT_EXT_LOW_2 : PORT_EMB_LOW_2};
			ST_FRQ_WR: req = '{write: 1'b1, addr: DEV_FREQUENCY_CONTROL_REG, wdata: frq_val};
			ST_MCLK_WR: req = '{write: 1'b1, addr: DEV_PHY_CLOCK_DIVIDER_REG,
				wdata: {8'h0, mclk_val}};
			ST_ID1_WR: req = '{write: 1'b1, addr: DEV_PHY_INTERFACE_BLOCK_ID_ONE, wdata: id_one};
			ST_ID2_WR: req = '{write: 1'b1, addr: DEV_PHY_INTERFACE_BLOCK_ID_TWO, wdata: id_two};
			ST_ADDR_WR: req = '{write: 1'b1, addr: DEV_PHY_INTERFACE_BLOCK_ADDRESS,
				wdata: {11'h0, phy_addr}};
			ST_CTRL_RST: req = '{write: 1'b1, addr: DEV_PHY_INTERFACE_BLOCK_CONTROL_REG, wdata: ctrl_word};
			ST_CTRL_REL: req = '{write: 1'b1, addr: DEV_PHY_INTERFACE_BLOCK_CONTROL_REG,
				wdata: ctrl_word | (16'h1 << CR_RESET_BIT)};
			default: req = '{write: 1'b1, addr: 32'h0, wdata: 16'h0};
		endcase
	end

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:
				if (start_ok)
					next_state = pwdata[CTRL_EXT_BIT] ? ST_PORT_H2 : ST_STOP_RD;
			ST_STOP_RD:
				if (xfer_done)
					next_state = stop_set ? ST_STOP_WR : ST_PWR_POLL;
			ST_STOP_WR:
				if (xfer_done)
					next_state = ST_PWR_POLL;
			ST_PWR_POLL:
				if (xfer_done & flag_clear)
					next_state = ST_PORT_H2;
			ST_PORT_H2:
				if (xfer_done)
					next_state = ST_PORT_L1;
			ST_PORT_L1:
				if (xfer_done)
					next_state = ST_PORT_L2;
			ST_PORT_L2:
				if (xfer_done) begin
					// external phy: its own registers are left to mii frames by software
					if (cfg_ext)
						next_state = ST_DONE;
					else
						next_state = cfg_intclk ? ST_FRQ_WR : ST_ID1_WR;
				end
			ST_FRQ_WR:
				if (xfer_done)
					next_state = ST_MCLK_WR;
			ST_MCLK_WR:
				if (xfer_done)
					next_state = ST_ID1_WR;
			ST_ID1_WR:
				if (xfer_done)
					next_state = ST_ID2_WR;
			ST_ID2_WR:
				if (xfer_done)
					next_state = ST_ADDR_WR;
			ST_ADDR_WR:
				if (xfer_done)
					next_state = ST_CTRL_RST;
			ST_CTRL_RST:
				if (xfer_done)
					next_state = ST_RST_WAIT;
			ST_RST_WAIT:
				if (timer_expired)
					next_state = ST_CTRL_REL;
			ST_CTRL_REL:
				if (xfer_done)
					next_state = ST_REL_WAIT;
			ST_REL_WAIT:
				if (timer_expired)
					next_state = ST_DONE;
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	pbs_wait_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(timer_load),
		.count(timer_count),
		.expired(timer_expired)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			stop_val <= 16'h0;
			seq_done <= 1'b0;
		end else begin
			state <= next_state;
			if (xfer_done & (state == ST_STOP_RD))
				stop_val <= m_prdata[15:0];
			// a new start clears the done flag; finishing sets it
			if (seq_finish)
				seq_done <= 1'b1;
			else if (start_ok)
				seq_done <= 1'b0;
		end
	end

	// master: request held unchanged from setup until pready is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_psel <= 1'b0;
			m_penable <= 1'b0;
			m_pwrite <= 1'b0;
			m_paddr <= 32'h0;
			m_pwdata <= 32'h0;
		end else if (launch) begin
			m_psel <= 1'b1;
			m_penable <= 1'b0;
			m_pwrite <= req.write;
			m_paddr <= req.addr;
			m_pwdata <= {16'h0, req.wdata};
		end else if (m_psel & ~m_penable) begin
			m_penable <= 1'b1;
		end else if (xfer_done) begin
			m_psel <= 1'b0;
			m_penable <= 1'b0;
		end
	end

	// slave: one wait-free access phase, answer registered in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? rdata : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ext <= 1'b0;
			cfg_intclk <= 1'b0;
			cfg_mode <= MODE_RESET_VALUE;
			id_one <= 16'h0;
			id_two <= 16'h0;
			phy_addr <= 5'h0;
			frq_val <= 16'h0;
			mclk_val <= 8'h0;
			irq_mask <= '0;
		end else begin
			if (start_ok) begin
				cfg_ext <= pwdata[CTRL_EXT_BIT];
				cfg_intclk <= pwdata[CTRL_INTCLK_BIT];
				cfg_mode <= wr_mode;
			end
			if (cfg_wr & hit_ident) begin
				id_one <= pwdata[15:0];
				id_two <= pwdata[31:16];
			end
			if (cfg_wr & hit_addr)
				phy_addr <= pwdata[4:0];
			if (cfg_wr & hit_clock) begin
				frq_val <= pwdata[15:0];
				mclk_val <= pwdata[23:16];
			end
			if (wr_en & hit_irq_mask)
				irq_mask <= pwdata[IRQ_WIDTH-1:0];
		end
	end

	// set beats clear so an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st <= '0;
			irq <= 1'b0;
		end else begin
			irq_st <= (irq_st & ~irq_clr) | irq_set;
			irq <= |(((irq_st & ~irq_clr) | irq_set) & irq_mask);
		end
	end

endmodule

`default_nettype wire

// ---- logic/pbs_pkg.sv ----
package pbs_pkg;

	// device register addresses, 16-bit data in the low half of the word
	localparam logic [31:0] DEV_STANDBY_CONTROL_FOUR = 32'hF80A0004;
	localparam logic [31:0] DEV_PHY_CLOCK_DIVIDER_REG = 32'hF80A000C;
	localparam logic [31:0] DEV_FREQUENCY_CONTROL_REG = 32'hF815FF80;
	localparam logic [31:0] DEV_PORT_C_FUNCTION_HIGH_2 = 32'hF805002A;
	localparam logic [31:0] DEV_PORT_C_FUNCTION_LOW_1 = 32'hF805002C;
	localparam logic [31:0] DEV_PORT_C_FUNCTION_LOW_2 = 32'hF805002E;
	localparam logic [31:0] DEV_PHY_INTERFACE_BLOCK_CONTROL_REG = 32'hF8490000;
	localparam logic [31:0] DEV_PHY_INTERFACE_BLOCK_ID_ONE = 32'hF8490004;
	localparam logic [31:0] DEV_PHY_INTERFACE_BLOCK_ID_TWO = 32'hF8490008;
	localparam logic [31:0] DEV_PHY_INTERFACE_BLOCK_ADDRESS = 32'hF849000C;
	localparam logic [31:0] DEV_PHY_INTERFACE_BLOCK_STATUS_REG = 32'hF8490010;

	// port c pin function values
	localparam logic [15:0] PORT_EMB_HIGH_2 = 16'h0000;
	localparam logic [15:0] PORT_EMB_LOW_1 = 16'h0000;
	localparam logic [15:0] PORT_EMB_LOW_2 = 16'hFF00;
	localparam logic [15:0] PORT_EXT_HIGH_2 = 16'h0155;
	localparam logic [15:0] PORT_EXT_LOW_1 = 16'h5555;
	localparam logic [15:0] PORT_EXT_LOW_2 = 16'h5555;

	// device control and status field positions
	localparam int CR_FIXED_BIT = 15;
	localparam int CR_RESET_BIT = 14;
	localparam int CR_CLKSEL_BIT = 13;
	localparam int SR_POWERUP_BIT = 15;
	localparam int STOP_BIT_POS = 0;
	localparam logic [2:0] MODE_RESERVED = 3'h5;
	localparam logic [2:0] MODE_RESET_VALUE = 3'h6;

	// own register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_IDENT = 8'h10;
	localparam logic [7:0] OFS_PHY_ADDR = 8'h14;
	localparam logic [7:0] OFS_CLOCK = 8'h18;

	// own control fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;
	localparam int CTRL_INTCLK_BIT = 2;
	localparam int CTRL_MODE_LSB = 4;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_REFUSED_BIT = 1;
	localparam int IRQ_WIDTH = 2;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int RST_HOLD_NS = 100000;
	localparam int REL_WAIT_MS = 20;
	localparam int RST_HOLD_CYCLES = RST_HOLD_NS / CLK_PERIOD_NS + 1;
	localparam int REL_WAIT_CYCLES = REL_WAIT_MS * 1000000 / CLK_PERIOD_NS + 1;
	localparam int TIMER_WIDTH = 20;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h00,
		ST_STOP_RD = 5'h01,
		ST_STOP_WR = 5'h02,
		ST_PWR_POLL = 5'h03,
		ST_PORT_H2 = 5'h04,
		ST_PORT_L1 = 5'h05,
		ST_PORT_L2 = 5'h06,
		ST_FRQ_WR = 5'h07,
		ST_MCLK_WR = 5'h08,
		ST_ID1_WR = 5'h09,
		ST_ID2_WR = 5'h0A,
		ST_ADDR_WR = 5'h0B,
		ST_CTRL_RST = 5'h0C,
		ST_RST_WAIT = 5'h0D,
		ST_CTRL_REL = 5'h0E,
		ST_REL_WAIT = 5'h0F,
		ST_DONE = 5'h10
	} pbs_state_t;

	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [15:0] wdata;
	} pbs_req_t;

endpackage

// ---- logic/pbs_wait_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_wait_timer import pbs_pkg::*; #(
	parameter int WIDTH = TIMER_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic expired
);

	logic [WIDTH-1:0] remain;
	wire last_tick = (remain == WIDTH'(1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain <= '0;
			expired <= 1'b0;
		end else begin
			if (load)
				remain <= count;
			else if (remain != '0)
				remain <= remain - WIDTH'(1);
			expired <= last_tick & ~load;
		end
	end

endmodule

`default_nettype wire

// ---- bench/pbs_seq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbs_seq_props import pbs_pkg::*; #(
	parameter int REL_WAIT = REL_WAIT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic m_psel,
	input wire logic m_penable,
	input wire logic m_pwrite,
	input wire logic [31:0] m_paddr,
	input wire logic [31:0] m_pwdata,
	input wire logic m_pready
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int hold_cnt;
	int rel_cnt;
	logic [15:0] last_ctrl;
	wire m_done = m_psel && m_penable && m_pready;
	wire ctrl_wr = m_done && m_pwrite && m_paddr == DEV_PHY_INTERFACE_BLOCK_CONTROL_REG;
	wire rst_wr = ctrl_wr && !m_pwdata[CR_RESET_BIT];
	wire rel_wr = ctrl_wr && m_pwdata[CR_RESET_BIT];
	wire bad_ofs = paddr > OFS_CLOCK || paddr[1:0] != 2'h0;
	// counters saturate so long idle runs cannot wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= 0;
			rel_cnt <= 1000000;
			last_ctrl <= 16'h0000;
		end else begin
			hold_cnt <= rst_wr ? 0 : (hold_cnt < 100000 ? hold_cnt + 1 : hold_cnt);
			rel_cnt <= rel_wr ? 0 : (rel_cnt < 1000000 ? rel_cnt + 1 : rel_cnt);
			last_ctrl <= ctrl_wr ? m_pwdata[15:0] : last_ctrl;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_m_setup;
		m_psel && !m_penable;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_unmapped_err: assert property (pready && bad_ofs |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && !bad_ofs |-> !pslverr)
		else $error("mapped access refused");
	a_mst_enable: assert property (s_m_setup |=> m_penable && m_psel && $stable(m_paddr)
		&& $stable(m_pwdata) && $stable(m_pwrite)) else $error("device setup not held");
	a_mst_hold: assert property (m_psel && m_penable && !m_pready |=> m_psel && m_penable
		&& $stable(m_paddr) && $stable(m_pwdata)) else $error("device request dropped");
	a_mst_gap: assert property (m_done |=> !m_psel)
		else $error("no idle cycle between device transfers");
	a_upper_zero: assert property (m_psel && m_pwrite |-> m_pwdata[31:16] == 16'h0)
		else $error("upper write data not zero");
	a_ctrl_fixed: assert property (rst_wr |-> m_pwdata[CR_FIXED_BIT])
		else $error("control fixed bit not one");
	a_reset_hold: assert property (rel_wr |-> hold_cnt >= RST_HOLD_CYCLES - 1)
		else $error("phy reset released too early");
	a_release_only: assert property (rel_wr |-> m_pwdata[15:0] == (last_ctrl | 16'h4000))
		else $error("release changed other control bits");
	a_release_wait: assert property (s_m_setup |-> rel_cnt >= REL_WAIT)
		else $error("device access too soon after release");
endmodule
bind pbs_seq pbs_seq_props #(.REL_WAIT(REL_WAIT)) pbs_seq_props_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .m_psel(m_psel), .m_penable(m_penable),
	.m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_pready(m_pready));
`default_nettype wire

// ---- bench/pbs_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbs_dev_model import pbs_pkg::*; #(
	parameter int PWR = 400
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic m_psel,
	input wire logic m_penable,
	input wire logic m_pwrite,
	input wire logic [31:0] m_paddr,
	input wire logic [31:0] m_pwdata,
	output logic [31:0] m_prdata,
	output logic m_pready
);
	logic [15:0] stby, frq, mclk, ph2, pl1, pl2, ctrl, id1, id2, addr, rdv;
	logic [15:0] lat_id1, lat_id2, lat_addr;
	logic [2:0] lat_mode;
	int pwr_cnt, wcnt, st_reads, ctrl_wr;
	int seed = 32'h7c8caebc;
	wire acc = m_psel && m_penable && m_pready;
	wire pwr_flag = pwr_cnt < PWR;
	wire phy_in_reset = !ctrl[CR_RESET_BIT];
	logic mac_link_q;
	int link_events;
	// outside link pin idles low here, so only the embedded link can raise it
	wire emb_sel = {ph2, pl1, pl2} == {PORT_EMB_HIGH_2, PORT_EMB_LOW_1, PORT_EMB_LOW_2};
	wire mac_link = emb_sel && !phy_in_reset;
	assign m_pready = m_psel && m_penable && wcnt == 0;
	always_comb begin
		case (m_paddr)
			DEV_STANDBY_CONTROL_FOUR: rdv = stby;
			DEV_PHY_INTERFACE_BLOCK_STATUS_REG: rdv = {pwr_flag, 15'h0000};
			DEV_PHY_INTERFACE_BLOCK_CONTROL_REG: rdv = ctrl;
			default: rdv = 16'hA5A5;
		endcase
	end
	// released bus shows inverted data, never a stale copy
	assign m_prdata = m_psel ? {16'h0000, rdv} : {16'hFFFF, ~rdv};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{frq, mclk, ph2, pl1, pl2, id1, id2, addr} <= '0;
			{lat_id1, lat_id2, lat_addr} <= '0;
			stby <= 16'h0001 << STOP_BIT_POS;
			ctrl <= 16'hC006;
			lat_mode <= MODE_RESET_VALUE;
			{pwr_cnt, wcnt, st_reads, ctrl_wr} <= '0;
			mac_link_q <= 1'b0;
			link_events <= 0;
		end else begin
			pwr_cnt <= pwr_flag ? pwr_cnt + 1 : pwr_cnt;
			mac_link_q <= mac_link;
			link_events <= link_events + (mac_link != mac_link_q);
			wcnt <= (m_psel && !m_penable) ? ($random(seed) & 3) : (wcnt > 0 ? wcnt - 1 : 0);
			st_reads <= st_reads + (acc && !m_pwrite && m_paddr == DEV_PHY_INTERFACE_BLOCK_STATUS_REG);
			if (acc && m_pwrite) begin
				case (m_paddr)
					DEV_STANDBY_CONTROL_FOUR: stby <= m_pwdata[15:0];
					DEV_FREQUENCY_CONTROL_REG: frq <= m_pwdata[15:0];
					DEV_PHY_CLOCK_DIVIDER_REG: mclk <= m_pwdata[15:0];
					DEV_PORT_C_FUNCTION_HIGH_2: ph2 <= m_pwdata[15:0];
					DEV_PORT_C_FUNCTION_LOW_1: pl1 <= m_pwdata[15:0];
					DEV_PORT_C_FUNCTION_LOW_2: pl2 <= m_pwdata[15:0];
					DEV_PHY_INTERFACE_BLOCK_ID_ONE: id1 <= m_pwdata[15:0];
					DEV_PHY_INTERFACE_BLOCK_ID_TWO: id2 <= m_pwdata[15:0];
					DEV_PHY_INTERFACE_BLOCK_ADDRESS: addr <= m_pwdata[15:0];
					DEV_PHY_INTERFACE_BLOCK_CONTROL_REG: begin
						ctrl <= m_pwdata[15:0];
						ctrl_wr <= ctrl_wr + 1;
						if (!m_pwdata[CR_RESET_BIT]) begin
							{lat_id1, lat_id2, lat_addr} <= {id1, id2, addr};
							lat_mode <= m_pwdata[2:0];
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/pbs_seq_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end
module pbs_seq_bench import pbs_pkg::*;;
	localparam int RW = 60;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
	logic m_psel, m_penable, m_pwrite, m_pready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, m_paddr, m_pwdata, m_prdata, rdat, id, ck, ctl;
	logic [4:0] ad;
	logic [2:0] mode;
	int bad_count, num_checks, cyc, cw0, run;
	int seed = 32'h7c8caebc;
	pbs_seq #(.REL_WAIT(RW)) pbs_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .m_psel(m_psel),
		.m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
		.m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
	pbs_dev_model pbs_dev_model_i (.pclk(pclk), .presetn(presetn), .m_psel(m_psel),
		.m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
		.m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// one full setup and access transfer plus a gap edge, so psel never gets two values in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// no own limit: only the run timeout ends a stalled access
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wait_irq();
		int k;
		for (k = 0; k < 6000 && irq !== 1'b1; k++) @(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFS_CTRL, 0);
		`CHK("ctrl_reset", 32'h00000060, rdat)
		apb(0, OFS_IRQ_MASK, 0);
		`CHK("mask_reset", 32'h00000000, rdat)
		apb(0, 8'h1C, 0);
		`CHK("unmapped_err", 1'b1, rerr)
		`CHK("unmapped_data", 32'h00000000, rdat)
		apb(1, OFS_IRQ_MASK, 32'h3);
		apb(1, OFS_CTRL, {25'h0, MODE_RESERVED, 4'h1});
		apb(0, OFS_IRQ_STATUS, 0);
		`CHK("refused_reserved", 32'h00000002, rdat)
		`CHK("irq_raised", 1'b1, irq)
		apb(1, OFS_IRQ_STATUS, 32'h2);
		`CHK("irq_cleared", 1'b0, irq)
		for (run = 0; run < 3; run++) begin
			id = $random(seed);
			ck = $random(seed);
			ad = $random(seed);
			do mode = $random(seed); while (mode == MODE_RESERVED);
			apb(1, OFS_IDENT, id);
			apb(1, OFS_PHY_ADDR, {27'h0, ad});
			apb(1, OFS_CLOCK, {8'h0, ck[23:0]});
			ctl = {25'h0, mode, 1'b0, run == 0, run == 1, 1'b1};
			cw0 = pbs_dev_model_i.ctrl_wr;
			apb(1, OFS_CTRL, ctl);
			if (run == 0) begin
				apb(1, OFS_CTRL, ctl);
				apb(0, OFS_IRQ_STATUS, 0);
				`CHK("busy_refused", 32'h00000002, rdat)
				apb(1, OFS_IRQ_STATUS, 32'h2);
			end
			wait_irq();
			apb(0, OFS_IRQ_STATUS, 0);
			`CHK("done_flag", 32'h00000001, rdat)
			apb(1, OFS_IRQ_STATUS, 32'h1);
			apb(0, OFS_STATUS, 0);
			`CHK("status_done", 32'h00000002, rdat)
			`CHK("link_routed", run != 1, pbs_dev_model_i.mac_link)
			`CHK("links", (run == 0) ? 3 : (run == 1) ? 4 : 7, pbs_dev_model_i.link_events)
			if (run != 1) begin
				`CHK("stop_cleared", 16'h0000, pbs_dev_model_i.stby)
				`CHK("polled", 1'b1, pbs_dev_model_i.st_reads > 1)
				`CHK("port_h2", PORT_EMB_HIGH_2, pbs_dev_model_i.ph2)
				`CHK("port_l1", PORT_EMB_LOW_1, pbs_dev_model_i.pl1)
				`CHK("port_l2", PORT_EMB_LOW_2, pbs_dev_model_i.pl2)
				`CHK("phy_running", 1'b0, pbs_dev_model_i.phy_in_reset)
				`CHK("id1", id[15:0], pbs_dev_model_i.lat_id1)
				`CHK("id2", id[31:16], pbs_dev_model_i.lat_id2)
				`CHK("addr", {11'h0, ad}, pbs_dev_model_i.lat_addr)
				`CHK("mode", mode, pbs_dev_model_i.lat_mode)
				`CHK("ctrl_final", {2'b11, run == 2, 10'h000, mode}, pbs_dev_model_i.ctrl)
			end
			if (run == 0) begin
				`CHK("freq", ck[15:0], pbs_dev_model_i.frq)
				`CHK("div", {8'h00, ck[23:16]}, pbs_dev_model_i.mclk)
			end
			if (run == 1) begin
				`CHK("ext_h2", PORT_EXT_HIGH_2, pbs_dev_model_i.ph2)
				`CHK("ext_l1", PORT_EXT_LOW_1, pbs_dev_model_i.pl1)
				`CHK("ext_l2", PORT_EXT_LOW_2, pbs_dev_model_i.pl2)
				`CHK("ext_no_reset", cw0, pbs_dev_model_i.ctrl_wr)
			end
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
